// file: rtl/dfm_monitor.sv
// Drive fault latches, enable gating and status indicators
`timescale 1ns/100ps

// Function
// R1 - Bus indicator red at power-up, green once charging resistor drops below 35 V.
// R2 - Bus indicator returns red on bus voltage trip while drive not enabled.
// R3 - Bus indicator green again once the bus voltage trip clears.
// R4 - Each hall indicator red on south pole, dark on north pole.
// R5 - Pickup indicator: A green, B red, both colours, none dark.
// R6 - Enable on in run, jog or ramp stop when no fault present.
// R7 - Enable off on timer expiry, any fault, or all modes inactive.
// R8 - Latch stall fault when no 30 degree movement within stall time.
// R9 - Stall time inversely proportional to current, 1.6 s at 150 percent.
// R10 - Stall timer never expires below 40 percent current.
// R11 - Stall fault clears only on trip reset.
// R12 - Latch supply-loss trip when raw 24 V supply below 18 V.
// R13 - Also latch supply-loss trip when 15 V rail within 3 V of 24 V.
// R14 - Reset clears supply-loss and bus trips only if cause has gone.
// R15 - Bus trip set at once when bus above 120 percent.
// R16 - Bus trip set at once when bus below 75 percent.
// R17 - Bus trip after 80 ms continuous below 85 percent; timer restarts on recovery.
// R18 - Bus trip set while charging bypass contactor not energized.
// R19 - Latch overcurrent trip above 300 percent; clears only on trip reset.
// R20 - Phase indicator green none, orange 18 degrees, red 30 degrees.
// R21 - Digital reference when mode input or forced jumper set, else analog.
// R22 - Internal jumper: stop resets faults; manual: only middle position resets.
// R23 - Enable held off while reset jumper in middle position.
// R24 - Stall timer accumulates current increment above 40 percent, clears on rotation.
// R25 - Multi-colour indicators are red and green enable pairs.
module dfm_monitor #(
	parameter longint STALL_CYCLES = dfm_pkg::STALL_CYCLES,
	parameter longint UV_CYCLES = dfm_pkg::UV_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire dfm_pkg::dfm_sense_t sense,
	input wire logic [dfm_pkg::CUR_W-1:0] motor_current,
	input wire logic [2:0] hall_input,
	input wire logic pickup_sensor_a,
	input wire logic pickup_sensor_b,
	input wire dfm_pkg::dfm_mode_t mode,
	input wire logic stop_cmd,
	input wire dfm_pkg::dfm_reset_pos_t mode_jumper_position,
	input wire logic digital_mode_in,
	input wire logic forced_digital_jumper,
	input wire dfm_pkg::dfm_phase_t phase_sel,
	output dfm_pkg::dfm_led_t bus_status_led,
	output logic [2:0] hall_led,
	output dfm_pkg::dfm_led_t speed_pickup_indicator,
	output logic drive_enable_out,
	output logic enable_led,
	output logic stall_trip,
	output logic rail_drop_trip,
	output logic bus_voltage_trip,
	output logic instant_overcurrent_trip,
	output dfm_pkg::dfm_led_t phase_shift_indicator,
	output logic use_digital_ref
);
	localparam int UV_W = 40;
	localparam logic [UV_W-1:0] UV_LIMIT = UV_CYCLES[UV_W-1:0];

	logic trip_reset;
	logic jumper_mid;
	logic bus_cause;
	logic rail_cause;
	logic any_fault;
	logic enable_nxt;
	logic uv_expired_r;
	logic [UV_W-1:0] uv_cnt_r;
	logic charged_r;
	logic [4:0] pos_r;
	logic rotated;
	logic stall_expired;

	// An unused jumper code is treated as the middle position, which is the safe one
	assign jumper_mid = (mode_jumper_position != dfm_pkg::DFM_RST_INT)
		&& (mode_jumper_position != dfm_pkg::DFM_RST_MAN);

	// Manual position deliberately ignores stop so that faults stay visible
	assign trip_reset = jumper_mid
		|| (mode_jumper_position == dfm_pkg::DFM_RST_INT && stop_cmd); // R22

	assign bus_cause = sense.bus_over120 // R15
		|| sense.bus_under75 // R16
		|| uv_expired_r // R17
		|| !sense.bypass_on; // R18

	assign rail_cause = sense.raw24_low || sense.rail15_high; // R12 R13

	assign any_fault = stall_trip || rail_drop_trip || bus_voltage_trip
		|| instant_overcurrent_trip || uv_expired_r;

	// Hold alone raises no enable; with all modes off the enable drops
	assign enable_nxt = (mode.run || mode.jog || mode.ramp_stop) // R6
		&& !any_fault && !jumper_mid; // R7 R23

	// Any change of hall or pickup state is taken as 30 degrees of movement
	assign rotated = (pos_r != {hall_input, pickup_sensor_a, pickup_sensor_b});

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pos_r <= '0;
		end else begin
			pos_r <= {hall_input, pickup_sensor_a, pickup_sensor_b};
		end
	end

	dfm_stall_timer #(
		.STALL_CYCLES(STALL_CYCLES)
	) u_stall (
		.mclk(mclk),
		.reset(reset),
		.motor_current(motor_current),
		.rotated(rotated),
		.clear(trip_reset),
		.expired(stall_expired)
	);

	// Undervoltage timer: counts while below 85 percent, restarts on recovery
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			uv_cnt_r <= '0;
			uv_expired_r <= dfm_pkg::RST_LOW;
		end else if (!sense.bus_under85) begin
			uv_cnt_r <= '0; // R17
			uv_expired_r <= 1'b0;
		end else if (uv_cnt_r < UV_LIMIT - 1'b1) begin
			uv_cnt_r <= uv_cnt_r + 1'b1;
			uv_expired_r <= 1'b0;
		end else begin
			uv_expired_r <= 1'b1; // R17
		end
	end

	// Fault latches: a set in the reset cycle wins over the clear
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			stall_trip <= dfm_pkg::RST_LOW;
		end else if (stall_expired) begin
			stall_trip <= 1'b1; // R8
		end else if (trip_reset) begin
			stall_trip <= 1'b0; // R11
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rail_drop_trip <= dfm_pkg::RST_LOW;
		end else if (rail_cause) begin
			rail_drop_trip <= 1'b1; // R12 R13
		end else if (trip_reset) begin
			rail_drop_trip <= 1'b0; // R14
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bus_voltage_trip <= dfm_pkg::RST_LOW;
		end else if (bus_cause) begin
			bus_voltage_trip <= 1'b1; // R15 R16 R17 R18
		end else if (trip_reset) begin
			bus_voltage_trip <= 1'b0; // R14
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			instant_overcurrent_trip <= dfm_pkg::RST_LOW;
		end else if (sense.ioc_over300) begin
			instant_overcurrent_trip <= 1'b1; // R19
		end else if (trip_reset) begin
			instant_overcurrent_trip <= 1'b0; // R19
		end
	end

	// Drive enable and its indicator
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			drive_enable_out <= dfm_pkg::RST_LOW;
			enable_led <= dfm_pkg::RST_LOW;
		end else begin
			drive_enable_out <= enable_nxt; // R6 R7
			enable_led <= enable_nxt;
		end
	end

	// Charge state: once the charging resistor threshold is seen it stays charged until reset
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			charged_r <= dfm_pkg::RST_LOW;
		end else if (sense.chg_res_low) begin
			charged_r <= 1'b1; // R1
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bus_status_led <= dfm_pkg::dfm_led(1'b1, 1'b0); // R1
		end else if (!charged_r || (bus_voltage_trip && !drive_enable_out)) begin
			bus_status_led <= dfm_pkg::dfm_led(1'b1, 1'b0); // R1 R2
		end else begin
			bus_status_led <= dfm_pkg::dfm_led(1'b0, 1'b1); // R3
		end
	end

	// Position indicators
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			hall_led <= '0;
			speed_pickup_indicator <= dfm_pkg::LED_OFF;
		end else begin
			hall_led <= hall_input; // R4
			speed_pickup_indicator <= dfm_pkg::dfm_led(pickup_sensor_b, pickup_sensor_a); // R5 R25
		end
	end

	// Phase advance indicator and reference selection
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			phase_shift_indicator <= dfm_pkg::LED_OFF;
		end else begin
			unique case (phase_sel)
				dfm_pkg::DFM_PH_NONE: phase_shift_indicator <= dfm_pkg::dfm_led(1'b0, 1'b1); // R20
				dfm_pkg::DFM_PH_18: phase_shift_indicator <= dfm_pkg::dfm_led(1'b1, 1'b1); // R20 R25
				dfm_pkg::DFM_PH_30: phase_shift_indicator <= dfm_pkg::dfm_led(1'b1, 1'b0); // R20
				default: phase_shift_indicator <= dfm_pkg::LED_OFF;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			use_digital_ref <= dfm_pkg::RST_LOW;
		end else begin
			use_digital_ref <= digital_mode_in || forced_digital_jumper; // R21
		end
	end

endmodule // dfm_monitor

// file: rtl/dfm_pkg.sv
// Shared constants, types and decode helpers for the drive fault and status monitor
package dfm_pkg;

	// Clock rate and documented times
	localparam longint CLK_HZ = 125000000;
	localparam longint STALL_TIME_MS = 1600;
	localparam longint UV_TIME_MS = 80;
	localparam longint STALL_CYCLES = STALL_TIME_MS * CLK_HZ / 1000;
	localparam longint UV_CYCLES = UV_TIME_MS * CLK_HZ / 1000;

	// Current thresholds in percent of full-load current
	localparam int CUR_W = 8;
	localparam logic [CUR_W-1:0] STALL_MIN_PCT = 8'h28;
	localparam logic [CUR_W-1:0] STALL_REF_PCT = 8'h96;

	// Stall accumulator width: holds STALL_REF_PCT times STALL_CYCLES
	localparam int STALL_ACC_W = 40;

	// Reset values
	localparam logic RST_LOW = 1'b0;

	typedef enum logic [1:0] {
		DFM_RST_INT = 2'b00,
		DFM_RST_MAN = 2'b01,
		DFM_RST_MID = 2'b10
	} dfm_reset_pos_t;

	typedef enum logic [1:0] {
		DFM_PH_NONE = 2'b00,
		DFM_PH_18 = 2'b01,
		DFM_PH_30 = 2'b10
	} dfm_phase_t;

	// Two-colour indicator: both enables together give orange
	typedef struct packed {
		logic red;
		logic green;
	} dfm_led_t;

	// Comparator results from the power stage, all active high
	typedef struct packed {
		logic chg_res_low;
		logic bus_over120;
		logic bus_under75;
		logic bus_under85;
		logic bypass_on;
		logic raw24_low;
		logic rail15_high;
		logic ioc_over300;
	} dfm_sense_t;

	// Operator modes, active high
	typedef struct packed {
		logic run;
		logic jog;
		logic hold;
		logic ramp_stop;
	} dfm_mode_t;

	localparam dfm_led_t LED_OFF = 2'b00;

	function automatic dfm_led_t dfm_led(input logic red, input logic green);
		dfm_led_t l;
		l.red = red;
		l.green = green;
		return l;
	endfunction

endpackage

// file: rtl/dfm_stall_timer.sv
// Current-weighted stall timer accumulator
`timescale 1ns/100ps
module dfm_stall_timer #(
	parameter longint STALL_CYCLES = dfm_pkg::STALL_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [dfm_pkg::CUR_W-1:0] motor_current,
	input wire logic rotated,
	input wire logic clear,
	output logic expired
);
	localparam longint LIMIT_L = longint'(dfm_pkg::STALL_REF_PCT) * STALL_CYCLES;
	localparam logic [dfm_pkg::STALL_ACC_W-1:0] LIMIT = LIMIT_L[dfm_pkg::STALL_ACC_W-1:0];

	logic [dfm_pkg::STALL_ACC_W-1:0] acc_r;
	logic [dfm_pkg::STALL_ACC_W-1:0] acc_nxt;
	logic [dfm_pkg::STALL_ACC_W-1:0] inc;

	assign inc = {{(dfm_pkg::STALL_ACC_W-dfm_pkg::CUR_W){1'b0}}, motor_current};

	// Time to expiry = LIMIT / current, so it shrinks inversely with current
	always_comb begin
		acc_nxt = acc_r;
		if (rotated || clear) begin
			acc_nxt = '0; // R24
		end else if (motor_current >= dfm_pkg::STALL_MIN_PCT && acc_r < LIMIT) begin
			acc_nxt = acc_r + inc; // R9 R10 R24
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			acc_r <= '0;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			expired <= dfm_pkg::RST_LOW;
		end else begin
			expired <= (acc_nxt >= LIMIT); // R9
		end
	end

endmodule // dfm_stall_timer

// file: dv/dfm_properties.sv
// Port assertions for the drive fault monitor, bound to its top module
`timescale 1ns/100ps
module dfm_chk (
	input wire logic mclk,
	input wire logic reset,
	input wire dfm_pkg::dfm_sense_t sense,
	input wire logic [2:0] hall_input,
	input wire dfm_pkg::dfm_reset_pos_t mode_jumper_position,
	input wire logic [2:0] hall_led,
	input wire logic drive_enable_out,
	input wire logic stall_trip,
	input wire logic rail_drop_trip,
	input wire logic bus_voltage_trip,
	input wire logic instant_overcurrent_trip
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);
	sequence s_ioc_set;
		sense.ioc_over300 ##1 instant_overcurrent_trip;
	endsequence
	property p_ioc; sense.ioc_over300 |=> instant_overcurrent_trip; endproperty
	a_ioc: assert property (p_ioc) else $error("ioc trip missing");
	property p_ioc_off; s_ioc_set |=> !drive_enable_out; endproperty
	a_ioc_off: assert property (p_ioc_off) else $error("enable kept on ioc");
	property p_ovr; sense.bus_over120 |=> bus_voltage_trip; endproperty
	a_ovr: assert property (p_ovr) else $error("overvoltage trip missing");
	property p_u75; sense.bus_under75 |=> bus_voltage_trip; endproperty
	a_u75: assert property (p_u75) else $error("low bus trip missing");
	property p_byp; !sense.bypass_on |=> bus_voltage_trip; endproperty
	a_byp: assert property (p_byp) else $error("contactor trip missing");
	property p_rail; sense.raw24_low || sense.rail15_high |=> rail_drop_trip; endproperty
	a_rail: assert property (p_rail) else $error("supply trip missing");
	property p_mid; mode_jumper_position[1] |=> !drive_enable_out; endproperty
	a_mid: assert property (p_mid) else $error("enable in middle position");
	property p_hall; !$past(reset) |-> hall_led == $past(hall_input); endproperty
	a_hall: assert property (p_hall) else $error("hall lamp wrong");
	// Manual position must ignore stop, so only the middle position may clear
	property p_hold; stall_trip && mode_jumper_position == dfm_pkg::DFM_RST_MAN |=> stall_trip;
	endproperty
	a_hold: assert property (p_hold) else $error("stall trip lost");
endmodule // dfm_chk

bind dfm_monitor dfm_chk i_chk (.mclk, .reset, .sense, .hall_input, .mode_jumper_position,
	.hall_led, .drive_enable_out, .stall_trip, .rail_drop_trip, .bus_voltage_trip,
	.instant_overcurrent_trip);

// file: dv/dfm_plant.sv
// Stand-in for the power stage comparators and the hall encoder
`timescale 1ns/100ps
module dfm_plant (
	input wire logic mclk,
	input wire logic reset,
	input wire logic spin,
	input wire dfm_pkg::dfm_sense_t inj,
	output dfm_pkg::dfm_sense_t sense,
	output logic [2:0] hall_input
);
	localparam logic [2:0] HALL [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
	logic [3:0] chg_r;
	logic [2:0] pos_r;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			chg_r <= 4'h0;
		else if (chg_r != 4'hF)
			chg_r <= chg_r + 4'h1;
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			pos_r <= 3'h0;
		else if (spin)
			pos_r <= (pos_r == 3'h5) ? 3'h0 : pos_r + 3'h1;
	end
	// Injected bits flip the charge and contactor feedback, so a set bit there is a fault
	assign sense = inj ^ {&chg_r, 3'h0, &chg_r, 3'h0};
	assign hall_input = HALL[pos_r];
endmodule // dfm_plant

// file: dv/dfm_monitor_bench.sv
// Self-checking bench for the drive fault and status monitor
`timescale 1ns/100ps
module dfm_monitor_bench;
	logic mclk;
	logic reset = 1'b1;
	logic spin = 1'b0, pa = 1'b0, pb = 1'b0, stop = 1'b0, dmi = 1'b0, fdj = 1'b0;
	logic [7:0] cur = 8'h00;
	dfm_pkg::dfm_sense_t inj = 8'h00, sense;
	dfm_pkg::dfm_mode_t mode = 4'h0;
	dfm_pkg::dfm_reset_pos_t jp = dfm_pkg::DFM_RST_INT;
	dfm_pkg::dfm_phase_t ph = dfm_pkg::DFM_PH_NONE;
	logic [2:0] hall, hall_led, hall_s;
	dfm_pkg::dfm_led_t bus_status_led, speed_pickup_indicator, phase_shift_indicator;
	logic drive_enable_out, enable_led, stall_trip, rail_drop_trip, bus_voltage_trip;
	logic instant_overcurrent_trip, use_digital_ref;
	logic [31:0] lf = 32'hC096;
	int fail_count = 0, checked = 0;
	int sel_q[$];
	logic [3:0] exp_q[$];
	logic [3:0] obs[7];
	string nm[7] = '{"bus", "hall", "pick", "enable", "trips", "phase", "ref"};
	logic [7:0] fm[6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h40};
	logic [3:0] fe[6] = '{4'h1, 4'h4, 4'h4, 4'h2, 4'h2, 4'h2};
	dfm_plant i_plant (.mclk, .reset, .spin, .inj, .sense, .hall_input(hall));
	dfm_monitor #(.STALL_CYCLES(4), .UV_CYCLES(20)) i_dut (.mclk, .reset, .sense,
		.motor_current(cur), .hall_input(hall), .pickup_sensor_a(pa), .pickup_sensor_b(pb),
		.mode, .stop_cmd(stop), .mode_jumper_position(jp), .digital_mode_in(dmi),
		.forced_digital_jumper(fdj), .phase_sel(ph), .bus_status_led, .hall_led,
		.speed_pickup_indicator, .drive_enable_out, .enable_led, .stall_trip, .rail_drop_trip,
		.bus_voltage_trip, .instant_overcurrent_trip, .phase_shift_indicator, .use_digital_ref);
	always_comb begin
		obs[0] = {2'h0, bus_status_led};
		obs[1] = {1'h0, hall_led};
		obs[2] = {2'h0, speed_pickup_indicator};
		obs[3] = {2'h0, drive_enable_out, enable_led};
		obs[4] = {stall_trip, rail_drop_trip, bus_voltage_trip, instant_overcurrent_trip};
		obs[5] = {2'h0, phase_shift_indicator};
		obs[6] = {3'h0, use_digital_ref};
	end
	// Hall value as the design samples it; avoids reading the plant in its own edge step
	always @(negedge mclk) hall_s <= hall;
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic t(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Notes are taken just after the sampling edge; the monitor compares half a cycle later
	task automatic note(input int s, input logic [3:0] e);
		sel_q.push_back(s);
		exp_q.push_back(e);
	endtask
	task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	always @(negedge mclk) begin : mon
		int s;
		while (sel_q.size() > 0) begin
			s = sel_q.pop_front();
			check(nm[s], obs[s], exp_q.pop_front());
		end
	end
	task automatic conclude;
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		t(2000);
		fail_count++;
		conclude();
	end
	initial begin
		t(5);
		reset <= 1'b0;
		t(1);
		note(0, 4'h2);
		t(20);
		jp <= dfm_pkg::DFM_RST_MID;
		t(2);
		jp <= dfm_pkg::DFM_RST_INT;
		t(2);
		note(0, 4'h1);
		$display("power-up done");
		spin <= 1'b1;
		repeat (40) begin
			lf = lfsr(lf);
			pa <= lf[0];
			pb <= lf[1];
			ph <= dfm_pkg::dfm_phase_t'(lf[3:2]);
			dmi <= lf[4];
			fdj <= lf[5];
			t(1);
			note(1, {1'h0, hall_s});
			note(2, {2'h0, pb, pa});
			note(5, {2'h0, ^ph, ~ph[1]});
			note(6, {3'h0, dmi | fdj});
		end
		$display("indicators done");
		for (int i = 0; i < 5; i++) begin
			mode <= dfm_pkg::dfm_mode_t'(4'h1 << i);
			t(2);
			note(3, (i == 1 || i == 4) ? 4'h0 : 4'h3);
		end
		$display("modes done");
		mode <= dfm_pkg::dfm_mode_t'(4'h8);
		foreach (fm[k]) begin
			inj <= fm[k];
			t(1);
			note(4, fe[k]);
			t(1);
			note(3, 4'h0);
			jp <= dfm_pkg::DFM_RST_MID;
			t(1);
			note(4, fe[k]);
			if (fe[k] == 4'h2)
				note(0, 4'h2);
			inj <= 8'h00;
			t(1);
			note(4, 4'h0);
			note(3, 4'h0);
			jp <= dfm_pkg::DFM_RST_INT;
			t(1);
			if (fe[k] == 4'h2)
				note(0, 4'h1);
			t(2);
			note(3, 4'h3);
		end
		$display("trips done");
		inj <= 8'h10;
		t(12);
		inj <= 8'h00;
		t(1);
		inj <= 8'h10;
		t(18);
		note(4, 4'h0);
		t(8);
		note(4, 4'h2);
		inj <= 8'h00;
		jp <= dfm_pkg::DFM_RST_MID;
		t(2);
		jp <= dfm_pkg::DFM_RST_INT;
		t(3);
		note(4, 4'h0);
		$display("undervoltage timer done");
		spin <= 1'b0;
		cur <= 8'h27;
		t(40);
		note(4, 4'h0);
		cur <= 8'h96;
		t(3);
		note(4, 4'h0);
		t(5);
		note(4, 4'h8);
		cur <= 8'h00;
		jp <= dfm_pkg::DFM_RST_MAN;
		stop <= 1'b1;
		t(3);
		note(4, 4'h8);
		jp <= dfm_pkg::DFM_RST_INT;
		t(2);
		note(4, 4'h0);
		stop <= 1'b0;
		t(2);
		$display("stall done");
		conclude();
	end
endmodule // dfm_monitor_bench
